// File: vpint_pkg.sv
// Constants and carrier types for the video port interrupt enable block
package vpint_pkg;

    localparam int DATA_W = 32;
    localparam int ADDR_W = 8;
    localparam int STRB_W = 4;
    localparam int BYTE_W = 8;

    // Register byte offsets
    localparam logic [7:0] OFF_ENABLE = 8'h00;
    localparam logic [7:0] OFF_STATUS = 8'h04;
    localparam logic [7:0] WORD_MASK = 8'hFC;

    // Implemented bits: enable holds the global bit, status does not
    localparam logic [31:0] EN_MASK = 32'h00FF7CFF;
    localparam logic [31:0] STATUS_MASK = 32'h00FF7CFE;
    localparam logic [31:0] EN_RESET = 32'h00000000;
    localparam logic [31:0] STATUS_RESET = 32'h00000000;

    // Field positions
    localparam int LONG_FIELD_B_EN = 23;
    localparam int CAPTURE_OVERRUN_B_EN = 17;
    localparam int GPIO_EN = 16;
    localparam int DISPLAY_DONE_UNACKED_EN = 14;
    localparam int DISPLAY_DONE_EN = 13;
    localparam int DISPLAY_UNDERRUN_EN = 12;
    localparam int TIME_CLOCK_TICK_EN = 11;
    localparam int TIME_CLOCK_COMPARE_EN = 10;
    localparam int LONG_FIELD_A_EN = 7;
    localparam int CAPTURE_OVERRUN_A_EN = 1;
    localparam int GLOBAL_IRQ_EN = 0;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Held write request
    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic [STRB_W-1:0] strb;
    } vpint_wr_type;

    // Status flag update: hardware sets, software clears
    typedef struct packed {
        logic [DATA_W-1:0] set;
        logic [DATA_W-1:0] clr;
    } vpint_flag_upd_type;

endpackage

// File: vpint_status_bank.sv
// Sticky interrupt status flags, write one to clear
`timescale 1ns/1ps
module vpint_status_bank (
    input logic aclk,
    input logic aresetn,
    input vpint_pkg::vpint_flag_upd_type upd,
    output logic [vpint_pkg::DATA_W-1:0] status_q
);

    logic [vpint_pkg::DATA_W-1:0] status_d;

    // Per flag next value, set wins over clear
    for (genvar i = 0; i < vpint_pkg::DATA_W; i++) begin : g_flag
        always_comb begin
            status_d[i] = upd.set[i] | (status_q[i] & ~upd.clr[i]);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_q <= vpint_pkg::STATUS_RESET;
        end else begin
            status_q <= status_d & vpint_pkg::STATUS_MASK;
        end
    end

endmodule

// File: vpint_irq_gate.sv
// Interrupt combiner: pending flags gated by enables and global enable
`timescale 1ns/1ps
module vpint_irq_gate (
    input logic aclk,
    input logic aresetn,
    input logic [vpint_pkg::DATA_W-1:0] enable,
    input logic [vpint_pkg::DATA_W-1:0] status,
    output logic irq_q
);

    logic [vpint_pkg::DATA_W-1:0] contrib;
    logic irq_d;

    // Per source gating
    for (genvar i = 0; i < vpint_pkg::DATA_W; i++) begin : g_src
        always_comb begin
            contrib[i] = status[i] & enable[i] & vpint_pkg::STATUS_MASK[i];
        end
    end

    always_comb begin
        irq_d = enable[vpint_pkg::GLOBAL_IRQ_EN] & (|contrib);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_q <= 1'b0;
        end else begin
            irq_q <= irq_d;
        end
    end

endmodule

// File: vpint_top.sv
// Video port interrupt enable and status registers on AXI4-Lite
//
// Contract
// - Each event source reaches the interrupt only while its enable bit is set.
// - Reserved enable bits read zero and ignore writes.
// - Implemented enable bits are read/write and reset to zero.
// - Bits 23..17 enable the seven channel B capture sources.
// - Bit 16 enables the general purpose I/O source.
// - Bit 14 enables display done unacknowledged, bit 13 display done.
// - Bit 12 enables the display underrun source.
// - Bit 11 enables the time clock tick source.
// - Bit 10 enables time clock compare; bits 9 and 8 read zero.
// - Bits 7..1 enable the seven channel A sources, same order as B.
// - Bit 0 is a global enable; without it no interrupt leaves.
// - Separate status flags, same positions, write one clears; only enabled ones count.
`timescale 1ns/1ps
module vpint_top (
    input logic aclk,
    input logic aresetn,
    input logic [vpint_pkg::ADDR_W-1:0] awaddr,
    input logic [2:0] awprot,
    input logic awvalid,
    output logic awready,
    input logic [vpint_pkg::DATA_W-1:0] wdata,
    input logic [vpint_pkg::STRB_W-1:0] wstrb,
    input logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input logic bready,
    input logic [vpint_pkg::ADDR_W-1:0] araddr,
    input logic [2:0] arprot,
    input logic arvalid,
    output logic arready,
    output logic [vpint_pkg::DATA_W-1:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input logic rready,
    input logic [vpint_pkg::DATA_W-1:0] src_event,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    vpint_pkg::vpint_wr_type wr_q, wr_d;
    vpint_pkg::vpint_flag_upd_type upd;
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic awready_q, awready_d;
    logic wready_q, wready_d;
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic arready_q, arready_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [vpint_pkg::DATA_W-1:0] rdata_q, rdata_d;
    logic [vpint_pkg::DATA_W-1:0] en_q, en_d;
    logic [vpint_pkg::DATA_W-1:0] status;
    logic [vpint_pkg::DATA_W-1:0] lane_mask;
    logic [vpint_pkg::ADDR_W-1:0] rd_addr;
    logic wr_fire, wr_en_hit, wr_st_hit, rd_fire;
    logic irq_q;

    ////////////////////////////////////////////////////////////////////////////
    // Write strobe lanes
    for (genvar g = 0; g < vpint_pkg::STRB_W; g++) begin : g_lane
        always_comb begin
            lane_mask[g*vpint_pkg::BYTE_W +: vpint_pkg::BYTE_W] =
                {vpint_pkg::BYTE_W{wr_q.strb[g]}};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Write channels
    always_comb begin
        wr_fire = aw_held_q && w_held_q && !bvalid_q;
        wr_en_hit = (wr_q.addr == vpint_pkg::OFF_ENABLE);
        wr_st_hit = (wr_q.addr == vpint_pkg::OFF_STATUS);
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        wr_d = wr_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        if (awvalid && awready_q) begin
            aw_held_d = 1'b1;
            wr_d.addr = awaddr & vpint_pkg::WORD_MASK;
        end
        if (wvalid && wready_q) begin
            w_held_d = 1'b1;
            wr_d.data = wdata;
            wr_d.strb = wstrb;
        end
        if (wr_fire) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            bvalid_d = 1'b1;
            if (wr_en_hit || wr_st_hit) begin
                bresp_d = vpint_pkg::RESP_OKAY;
            end else begin
                bresp_d = vpint_pkg::RESP_SLVERR;
            end
        end
        if (bvalid_q && bready) begin
            bvalid_d = 1'b0;
        end
        awready_d = !aw_held_d && !bvalid_d;
        wready_d = !w_held_d && !bvalid_d;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable register and status updates
    always_comb begin
        en_d = en_q;
        if (wr_fire && wr_en_hit) begin
            en_d = ((en_q & ~lane_mask) | (wr_q.data & lane_mask))
                & vpint_pkg::EN_MASK;
        end
        upd.set = src_event & vpint_pkg::STATUS_MASK;
        if (wr_fire && wr_st_hit) begin
            upd.clr = wr_q.data & lane_mask & vpint_pkg::STATUS_MASK;
        end else begin
            upd.clr = '0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read channels
    always_comb begin
        rd_fire = arvalid && arready_q;
        rd_addr = araddr & vpint_pkg::WORD_MASK;
        arready_d = arready_q;
        rvalid_d = rvalid_q;
        rdata_d = rdata_q;
        rresp_d = rresp_q;
        if (rvalid_q && rready) begin
            rvalid_d = 1'b0;
            arready_d = 1'b1;
        end
        if (!arready_q && !rvalid_q) begin
            arready_d = 1'b1;
        end
        if (rd_fire) begin
            arready_d = 1'b0;
            rvalid_d = 1'b1;
            rresp_d = vpint_pkg::RESP_OKAY;
            if (rd_addr == vpint_pkg::OFF_ENABLE) begin
                rdata_d = en_q & vpint_pkg::EN_MASK;
            end else if (rd_addr == vpint_pkg::OFF_STATUS) begin
                rdata_d = status & vpint_pkg::STATUS_MASK;
            end else begin
                rdata_d = '0;
                rresp_d = vpint_pkg::RESP_SLVERR;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wr_q <= '0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awready_q <= 1'b0;
            wready_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= vpint_pkg::RESP_OKAY;
            arready_q <= 1'b0;
            rvalid_q <= 1'b0;
            rdata_q <= '0;
            rresp_q <= vpint_pkg::RESP_OKAY;
            en_q <= vpint_pkg::EN_RESET;
        end else begin
            wr_q <= wr_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awready_q <= awready_d;
            wready_q <= wready_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            arready_q <= arready_d;
            rvalid_q <= rvalid_d;
            rdata_q <= rdata_d;
            rresp_q <= rresp_d;
            en_q <= en_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Submodules
    vpint_status_bank u_status (
        .aclk(aclk),
        .aresetn(aresetn),
        .upd(upd),
        .status_q(status)
    );

    vpint_irq_gate u_gate (
        .aclk(aclk),
        .aresetn(aresetn),
        .enable(en_q),
        .status(status),
        .irq_q(irq_q)
    );

    always_comb begin
        awready = awready_q;
        wready = wready_q;
        bvalid = bvalid_q;
        bresp = bresp_q;
        arready = arready_q;
        rvalid = rvalid_q;
        rdata = rdata_q;
        rresp = rresp_q;
        irq = irq_q;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    a_reserved_zero: assert property (
        rvalid_q |-> ((rdata_q & ~vpint_pkg::EN_MASK & ~vpint_pkg::STATUS_MASK) == '0))
        else $error("reserved bits read nonzero");

    a_reset_clear: assert property (
        !$past(aresetn) |-> (en_q == '0 && status == '0 && !irq_q))
        else $error("state not cleared by reset");

    a_enable_write: assert property (
        (wr_fire && wr_en_hit && wr_q.strb == '1)
        |=> (en_q == ($past(wr_q.data) & vpint_pkg::EN_MASK)))
        else $error("enable write not stored");

    a_irq_equation: assert property (
        irq_q == $past(en_q[vpint_pkg::GLOBAL_IRQ_EN]
            & (|(status & en_q & vpint_pkg::STATUS_MASK))))
        else $error("interrupt does not follow gated flags");

    a_global_gate: assert property (
        !en_q[vpint_pkg::GLOBAL_IRQ_EN] |=> !irq_q)
        else $error("interrupt without global enable");

    a_source_off: assert property (
        ((status & en_q & vpint_pkg::STATUS_MASK) == '0) |=> !irq_q)
        else $error("interrupt from disabled source");

    a_chb_source: assert property (
        (status[vpint_pkg::LONG_FIELD_B_EN] && en_q[vpint_pkg::LONG_FIELD_B_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("channel B source not raising interrupt");

    a_gpio_source: assert property (
        (status[vpint_pkg::GPIO_EN] && en_q[vpint_pkg::GPIO_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("gpio source not raising interrupt");

    a_disp_source: assert property (
        (status[vpint_pkg::DISPLAY_DONE_UNACKED_EN] && en_q[vpint_pkg::DISPLAY_DONE_UNACKED_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("display source not raising interrupt");

    a_under_source: assert property (
        (status[vpint_pkg::DISPLAY_UNDERRUN_EN] && en_q[vpint_pkg::DISPLAY_UNDERRUN_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("underrun source not raising interrupt");

    a_tick_source: assert property (
        (status[vpint_pkg::TIME_CLOCK_TICK_EN] && en_q[vpint_pkg::TIME_CLOCK_TICK_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("tick source not raising interrupt");

    a_stc_source: assert property (
        (status[vpint_pkg::TIME_CLOCK_COMPARE_EN] && en_q[vpint_pkg::TIME_CLOCK_COMPARE_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("compare source not raising interrupt");

    a_cha_source: assert property (
        (status[vpint_pkg::CAPTURE_OVERRUN_A_EN] && en_q[vpint_pkg::CAPTURE_OVERRUN_A_EN]
            && en_q[vpint_pkg::GLOBAL_IRQ_EN]) |=> irq_q)
        else $error("channel A source not raising interrupt");

    a_set_wins: assert property (
        src_event[vpint_pkg::GPIO_EN] |=> status[vpint_pkg::GPIO_EN])
        else $error("event lost");

    a_w1c_clear: assert property (
        (upd.clr[vpint_pkg::GPIO_EN] && !src_event[vpint_pkg::GPIO_EN])
        |=> !status[vpint_pkg::GPIO_EN])
        else $error("write one did not clear flag");

    a_bus_answer: assert property (
        (arvalid && arready_q) |=> (rvalid_q && !arready_q))
        else $error("read not answered next cycle");

    a_resp_hold: assert property (
        (bvalid_q && !bready) |=> (bvalid_q && $stable(bresp_q)))
        else $error("write response dropped");

    c_enable_write: cover property (wr_fire && wr_en_hit);
    c_status_clear: cover property (wr_fire && wr_st_hit && (upd.clr != '0));
    c_irq_rise: cover property ($rose(irq_q));
    c_irq_fall: cover property ($fell(irq_q));

endmodule

// File: placeholder_end.sv
// Intentionally empty
`timescale 1ns/1ps

// File: test_video_port_interrupt_enable.sv
// Self-checking bench for the video port interrupt enable block
`timescale 1ns/1ps
module test_video_port_interrupt_enable;
    logic aclk;
    logic aresetn;
    logic [7:0] awaddr;
    logic awvalid;
    logic awready;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic wready;
    logic [1:0] bresp;
    logic bvalid;
    logic bready;
    logic [7:0] araddr;
    logic arvalid;
    logic arready;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic rvalid;
    logic rready;
    logic [31:0] src_event;
    logic irq;
    int n_fail;
    int samples_checked;

    vpint_top dut (
        .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .src_event(src_event), .irq(irq)
    );

    initial begin
        aclk = 1'b0;
        forever #25 aclk = ~aclk;
    end

    ////////////////////////////////////////////////////////////////////////
    // Helpers
    task automatic end_of_test();
        $display("checked %0d, failed %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Ready levels change only at rising edges, so the falling edge shows the sampled value
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             output logic [1:0] r);
        logic a_hs;
        logic w_hs;
        logic b_hs;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        b_hs = 1'b0;
        while (!b_hs) begin
            @(negedge aclk);
            a_hs = awvalid && awready;
            w_hs = wvalid && wready;
            b_hs = bready && bvalid;
            r = bresp;
            @(posedge aclk);
            if (a_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
        end
        bready <= 1'b0;
    endtask

    task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic a_hs;
        logic r_hs;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        r_hs = 1'b0;
        while (!r_hs) begin
            @(negedge aclk);
            a_hs = arvalid && arready;
            r_hs = rready && rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (a_hs) arvalid <= 1'b0;
        end
        rready <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [1:0] r;
        axi_write(a, d, 4'hF, r);
        check({30'h0, r}, {30'h0, vpint_pkg::RESP_OKAY});
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic [1:0] r;
        axi_read(a, d, r);
        check(d, exp);
        check({30'h0, r}, {30'h0, vpint_pkg::RESP_OKAY});
    endtask

    task automatic pulse(input logic [31:0] v);
        @(posedge aclk);
        src_event <= v;
        @(posedge aclk);
        src_event <= 32'h0;
        @(posedge aclk);
    endtask

    task automatic irq_chk(input logic exp);
        @(negedge aclk);
        check({31'h0, irq}, {31'h0, exp});
    endtask

    initial begin
        #(5000 * 50);
        n_fail++;
        $display("[FAIL] %0t watchdog expired", $time);
        end_of_test();
    end

    ////////////////////////////////////////////////////////////////////////
    // Tests
    initial begin
        logic [31:0] d;
        logic [31:0] bit_i;
        logic [1:0] r;
        n_fail = 0;
        samples_checked = 0;
        aresetn = 1'b0;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b0;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b0;
        src_event = 32'h0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;

        irq_chk(1'b0);
        rd_chk(vpint_pkg::OFF_ENABLE, vpint_pkg::EN_RESET);
        rd_chk(vpint_pkg::OFF_STATUS, vpint_pkg::STATUS_RESET);
        $display("test reset_values done");

        wr(vpint_pkg::OFF_ENABLE, 32'hFFFFFFFF);
        rd_chk(vpint_pkg::OFF_ENABLE, 32'h00FF7CFF);
        wr(vpint_pkg::OFF_ENABLE, 32'hFF0083FF);
        rd_chk(vpint_pkg::OFF_ENABLE, 32'h000000FF);
        wr(vpint_pkg::OFF_ENABLE, 32'h0);
        rd_chk(vpint_pkg::OFF_ENABLE, 32'h0);
        axi_write(vpint_pkg::OFF_ENABLE, 32'hFFFFFFFF, 4'h2, r);
        check({30'h0, r}, {30'h0, vpint_pkg::RESP_OKAY});
        rd_chk(vpint_pkg::OFF_ENABLE, 32'h00007C00);
        $display("test enable_access done");

        axi_write(8'h08, 32'hFFFFFFFF, 4'hF, r);
        check({30'h0, r}, {30'h0, vpint_pkg::RESP_SLVERR});
        axi_read(8'h08, d, r);
        check(d, 32'h0);
        check({30'h0, r}, {30'h0, vpint_pkg::RESP_SLVERR});
        rd_chk(vpint_pkg::OFF_ENABLE, 32'h00007C00);
        $display("test unmapped done");

        wr(vpint_pkg::OFF_ENABLE, 32'hFFFFFFFF);
        pulse(32'hFF008301);
        rd_chk(vpint_pkg::OFF_STATUS, 32'h0);
        irq_chk(1'b0);
        $display("test reserved_events done");

        for (int i = 1; i < 24; i++) begin
            if (vpint_pkg::STATUS_MASK[i]) begin
                bit_i = 32'h1 << i;
                wr(vpint_pkg::OFF_ENABLE, ~bit_i);
                pulse(bit_i);
                irq_chk(1'b0);
                rd_chk(vpint_pkg::OFF_STATUS, bit_i);
                wr(vpint_pkg::OFF_ENABLE, bit_i | 32'h1);
                irq_chk(1'b1);
                wr(vpint_pkg::OFF_ENABLE, bit_i);
                irq_chk(1'b0);
                wr(vpint_pkg::OFF_ENABLE, bit_i | 32'h1);
                wr(vpint_pkg::OFF_STATUS, 32'h0);
                irq_chk(1'b1);
                wr(vpint_pkg::OFF_STATUS, bit_i);
                irq_chk(1'b0);
                rd_chk(vpint_pkg::OFF_STATUS, 32'h0);
            end
        end
        $display("test per_source done");

        pulse(32'h00010002);
        axi_write(vpint_pkg::OFF_STATUS, 32'hFFFFFFFF, 4'h4, r);
        check({30'h0, r}, {30'h0, vpint_pkg::RESP_OKAY});
        rd_chk(vpint_pkg::OFF_STATUS, 32'h00000002);
        wr(vpint_pkg::OFF_STATUS, 32'h00000002);
        // Event lands on the very edge of the clear: set must win
        fork
            begin
                wr(vpint_pkg::OFF_STATUS, 32'h00010000);
            end
            begin
                repeat (2) @(posedge aclk);
                src_event <= 32'h00010000;
                @(posedge aclk);
                src_event <= 32'h0;
            end
        join
        rd_chk(vpint_pkg::OFF_STATUS, 32'h00010000);
        wr(vpint_pkg::OFF_STATUS, 32'h00010000);
        rd_chk(vpint_pkg::OFF_STATUS, 32'h0);
        $display("test status_clear done");

        end_of_test();
    end
endmodule
